// file: src/display_bias_enable_control.sv
/*
  enable, sequencing and fault control for a two-rail display bias supply:
  registers, mode decode, auto sequencing, discharge and short handling.
  assumes an external serial engine delivers register writes and reads as
  one-cycle strobes on ref_clk_i, and analog detectors arrive as levels.
*/
// What this block does
// - enable pin low forces shutdown and defaults
// - standby: boost off, rails float or discharge
// - mode 100 pins: each pin drives rail
// - mode 100 bits: each bit drives rail
// - mode 101 auto-sequences both rails on trigger
// - wake modes: second pin gates selected rails
// - mode 110 passes input supply through
// - mode 111 regulates selected rails
// - discharge paths follow control bits 4, 3
// - overvoltage flag sticky, read clears when gone
// - filtered positive short sets flag bit 3
// - filtered negative short sets flag bit 2
// - response field: report, bias off, all off
// - positive short filter time selectable
// - negative short filter time selectable
// - soft reset bit restores defaults, self clears
// - bit 0 selects pins or bits
// - rail targets latch on enable; boost immediate
module display_bias_enable_control
  import bias_ctrl_pkg::*;
#(
  parameter int SEQ_CYC  = CYC_SEQ,
  parameter int F100_CYC = CYC_100_US,
  parameter int F500_CYC = CYC_500_US,
  parameter int F1M_CYC  = CYC_1_MS,
  parameter int F2M_CYC  = CYC_2_MS
) (
  input  wire logic       ref_clk_i,            // reference clock
  input  wire logic       sys_rst_i,            // async reset, active high
  input  wire logic       clk_en_i,             // freezes state when low
  input  wire logic       global_enable_pin_i,  // device enable pin
  input  wire logic       pos_rail_enable_pin_i,// positive rail pin
  input  wire logic       neg_rail_enable_pin_i,// negative rail pin
  input  wire logic       reg_wr_i,             // register write strobe
  input  wire logic       reg_rd_i,             // register read strobe
  input  wire logic [7:0] reg_addr_i,           // register offset
  input  wire logic [7:0] reg_wdata_i,          // write data
  input  wire logic [7:0] pos_target_i,         // positive rail target code
  input  wire logic [7:0] neg_target_i,         // negative rail target code
  input  wire logic [7:0] boost_target_i,       // boost target code
  input  wire logic       boost_ovp_i,          // boost overvoltage level
  input  wire logic       pos_ocp_i,            // positive overcurrent level
  input  wire logic       neg_short_i,          // negative short level
  output logic [7:0]      reg_rdata_o,          // read data
  output logic            boost_en_o,           // bias boost on
  output logic            pos_en_o,             // positive rail on
  output logic            neg_en_o,             // negative rail on
  output logic            passthrough_o,        // boost passes input through
  output logic            pos_disch_o,          // positive discharge switch
  output logic            neg_disch_o,          // negative discharge switch
  output logic [7:0]      pos_target_o,         // latched positive target
  output logic [7:0]      neg_target_o,         // latched negative target
  output logic [7:0]      boost_target_o,       // live boost target
  output logic            backlight_off_o       // backlight shutdown request
);

  typedef enum logic [2:0] {
    SEQ_OFF     = 3'b000,
    SEQ_POS_ON  = 3'b001,
    SEQ_BOTH_ON = 3'b010,
    SEQ_NEG_OFF = 3'b011
  } seq_state_t;

  logic [7:0] dev_en_r;      // device enable register
  logic [7:0] bias_ctl_r;    // bias control register
  logic [7:0] short_resp_r;  // short response register
  logic [7:0] short_filt_r;  // short filter register
  logic [7:0] flags_r;       // sticky fault flags
  logic       latch_r;       // shutdown latch after short
  logic [2:0] pins_s;        // synchronised pins
  logic [2:0] det_s;         // synchronised detectors
  logic       gen_s;         // synchronised global enable
  logic       pos_pin_s;     // positive pin level
  logic       neg_pin_s;     // negative pin level
  logic       ovp_s;         // overvoltage level
  logic       pos_hit;       // filtered positive short
  logic       neg_hit;       // filtered negative short
  logic       hold_rst;      // shutdown or soft reset in force
  logic       flag_rd;       // read of the flag register
  logic       want_pos;      // decoded positive request
  logic       want_neg;      // decoded negative request
  logic       auto_req;      // auto sequence trigger
  logic       is_auto;       // auto sequence mode
  seq_state_t seq_r;         // sequencer state
  seq_state_t seq_nxt;       // sequencer next state
  logic [CNT_W-1:0] seq_cnt_r;  // inter-rail delay counter
  logic       seq_tick;      // delay expired
  logic       pos_on;        // final positive enable
  logic       neg_on;        // final negative enable
  bias_mode_t mode;          // decoded mode field

  // pins and detectors cross from the analog side through two flops
  sync2 #(.W(3)) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .d_i       ({global_enable_pin_i, pos_rail_enable_pin_i, neg_rail_enable_pin_i}),
    .q_o       (pins_s)
  );
  sync2 #(.W(3)) u_det_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .d_i       ({boost_ovp_i, pos_ocp_i, neg_short_i}),
    .q_o       (det_s)
  );
  assign gen_s     = pins_s[2];
  assign pos_pin_s = pins_s[1];
  assign neg_pin_s = pins_s[0];
  assign ovp_s     = det_s[2];

  // soft reset takes one cycle: the bit stands, then all registers clear
  assign hold_rst = !gen_s || dev_en_r[SOFT_RESET_BIT];
  assign flag_rd  = reg_rd_i && gen_s && (reg_addr_i == ADDR_FAULT_FLAGS);

  // positive and negative short filters
  short_filter #(.T_100(F100_CYC), .T_500(F500_CYC), .T_1M(F1M_CYC),
                 .T_2M(F2M_CYC)) u_pos_filt (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .clear_i   (hold_rst),
    .cond_i    (det_s[1]),
    .sel_i     (short_filt_r[POS_FILT_MSB:POS_FILT_LSB]),
    .hit_o     (pos_hit)
  );
  short_filter #(.T_100(F100_CYC), .T_500(F500_CYC), .T_1M(F1M_CYC),
                 .T_2M(F2M_CYC)) u_neg_filt (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .clear_i   (hold_rst),
    .cond_i    (det_s[0]),
    .sel_i     (short_filt_r[NEG_FILT_MSB:NEG_FILT_LSB]),
    .hit_o     (neg_hit)
  );

  // register writes; shutdown ignores traffic and forces defaults
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dev_en_r     <= RST_DEVICE_ENABLE;
      bias_ctl_r   <= RST_BIAS_CONTROL;
      short_resp_r <= RST_SHORT_RESPONSE;
      short_filt_r <= RST_SHORT_FILTER;
    end else if (clk_en_i) begin
      if (hold_rst) begin
        dev_en_r     <= RST_DEVICE_ENABLE;
        bias_ctl_r   <= RST_BIAS_CONTROL;
        short_resp_r <= RST_SHORT_RESPONSE;
        short_filt_r <= RST_SHORT_FILTER;
      end else if (reg_wr_i) begin
        case (reg_addr_i)
          ADDR_DEVICE_ENABLE:  dev_en_r     <= reg_wdata_i;
          ADDR_BIAS_CONTROL:   bias_ctl_r   <= reg_wdata_i;
          ADDR_SHORT_RESPONSE: short_resp_r <= reg_wdata_i;
          ADDR_SHORT_FILTER:   short_filt_r <= reg_wdata_i;
          default:             ;  // flags and unmapped ignore writes
        endcase
      end
    end
  end

  // sticky flags; a new event in the read cycle wins over the clear
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags_r <= '0;
    end else if (clk_en_i) begin
      if (hold_rst) begin
        flags_r <= '0;
      end else begin
        // overvoltage stays while the condition persists
        flags_r[OVP_FLAG_BIT] <= ovp_s || (flags_r[OVP_FLAG_BIT] && !flag_rd);
        flags_r[POS_SHORT_BIT] <= pos_hit || (flags_r[POS_SHORT_BIT] && !flag_rd);
        flags_r[NEG_SHORT_BIT] <= neg_hit || (flags_r[NEG_SHORT_BIT] && !flag_rd);
      end
    end
  end

  // short response latch: cleared by the flag read, like the flags
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      latch_r         <= 1'b0;
      backlight_off_o <= 1'b0;
    end else if (clk_en_i) begin
      if (hold_rst) begin
        latch_r         <= 1'b0;
        backlight_off_o <= 1'b0;
      end else if ((pos_hit || neg_hit) &&
                   short_resp_r[RESP_MSB:RESP_LSB] != RESP_REPORT) begin
        latch_r         <= 1'b1;
        backlight_off_o <= (short_resp_r[RESP_MSB:RESP_LSB] == RESP_OFF_ALL);
      end else if (flag_rd) begin
        latch_r         <= 1'b0;
        backlight_off_o <= 1'b0;
      end
    end
  end

  // read data; unmapped offsets read zero
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (clk_en_i) begin
      if (!gen_s) begin
        reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
        case (reg_addr_i)
          ADDR_DEVICE_ENABLE:  reg_rdata_o <= dev_en_r;
          ADDR_BIAS_CONTROL:   reg_rdata_o <= bias_ctl_r;
          ADDR_SHORT_RESPONSE: reg_rdata_o <= short_resp_r;
          ADDR_SHORT_FILTER:   reg_rdata_o <= short_filt_r;
          ADDR_FAULT_FLAGS:    reg_rdata_o <= flags_r;
          default:             reg_rdata_o <= '0;
        endcase
      end
    end
  end

  // mode decode; anything not listed is standby
  always_comb begin
    mode     = bias_mode_t'(bias_ctl_r[MODE_MSB:MODE_LSB]);
    want_pos = 1'b0;
    want_neg = 1'b0;
    auto_req = 1'b0;
    is_auto  = 1'b0;
    case (mode)
      MODE_DIRECT: begin
        if (bias_ctl_r[PIN_SEL_BIT]) begin
          want_pos = pos_pin_s;
          want_neg = neg_pin_s;
        end else begin
          want_pos = bias_ctl_r[POS_EN_BIT];
          want_neg = bias_ctl_r[NEG_EN_BIT];
        end
      end
      MODE_AUTO_SEQ: begin
        is_auto  = 1'b1;
        auto_req = bias_ctl_r[PIN_SEL_BIT] ? neg_pin_s :
                   (bias_ctl_r[POS_EN_BIT] && bias_ctl_r[NEG_EN_BIT]);
      end
      MODE_WAKE_PASS, MODE_WAKE_REG: begin
        want_pos = neg_pin_s && bias_ctl_r[POS_EN_BIT];
        want_neg = neg_pin_s && bias_ctl_r[NEG_EN_BIT];
      end
      default: begin
        want_pos = 1'b0;
        want_neg = 1'b0;
      end
    endcase
  end

  // auto sequencer: positive, delay, negative; off in reverse
  assign seq_tick = (seq_cnt_r + CNT_W'(1) >= CNT_W'(SEQ_CYC));
  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      SEQ_OFF:     if (is_auto && auto_req) seq_nxt = SEQ_POS_ON;
      SEQ_POS_ON:  if (!(is_auto && auto_req)) seq_nxt = SEQ_OFF;
                   else if (seq_tick) seq_nxt = SEQ_BOTH_ON;
      SEQ_BOTH_ON: if (!(is_auto && auto_req)) seq_nxt = SEQ_NEG_OFF;
      SEQ_NEG_OFF: if (is_auto && auto_req) seq_nxt = SEQ_BOTH_ON;
                   else if (seq_tick) seq_nxt = SEQ_OFF;
      default:     seq_nxt = SEQ_OFF;
    endcase
  end

  // sequencer state and delay counter
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seq_r     <= SEQ_OFF;
      seq_cnt_r <= '0;
    end else if (clk_en_i) begin
      if (hold_rst || latch_r) begin
        seq_r     <= SEQ_OFF;
        seq_cnt_r <= '0;
      end else begin
        seq_r     <= seq_nxt;
        seq_cnt_r <= (seq_nxt != seq_r) ? '0 : seq_cnt_r + CNT_W'(1);
      end
    end
  end

  // final enables: a short latch or shutdown overrides everything
  assign pos_on = !hold_rst && !latch_r &&
                  (is_auto ? (seq_r != SEQ_OFF) : want_pos);
  assign neg_on = !hold_rst && !latch_r &&
                  (is_auto ? (seq_r == SEQ_BOTH_ON) : want_neg);

  // power outputs, registered
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pos_en_o      <= 1'b0;
      neg_en_o      <= 1'b0;
      boost_en_o    <= 1'b0;
      passthrough_o <= 1'b0;
      pos_disch_o   <= 1'b0;
      neg_disch_o   <= 1'b0;
    end else if (clk_en_i) begin
      pos_en_o      <= pos_on;
      neg_en_o      <= neg_on;
      boost_en_o    <= pos_on || neg_on;
      // in passthrough, disabled rails are held at ground by discharge
      passthrough_o <= (pos_on || neg_on) && (mode == MODE_WAKE_PASS);
      pos_disch_o   <= !pos_on && !hold_rst &&
                       (bias_ctl_r[POS_DISCH_BIT] ||
                        (mode == MODE_WAKE_PASS && neg_on));
      neg_disch_o   <= !neg_on && !hold_rst &&
                       (bias_ctl_r[NEG_DISCH_BIT] ||
                        (mode == MODE_WAKE_PASS && pos_on));
    end
  end

  // rail targets latch on a rising enable; boost target is live
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pos_target_o   <= '0;
      neg_target_o   <= '0;
      boost_target_o <= '0;
    end else if (clk_en_i) begin
      boost_target_o <= boost_target_i;
      if (pos_on && !pos_en_o) pos_target_o <= pos_target_i;
      if (neg_on && !neg_en_o) neg_target_o <= neg_target_i;
    end
  end

  // assertions
  property p_shutdown;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && !gen_s |=> !pos_en_o && !neg_en_o && !boost_en_o;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("rail on in shutdown");

  property p_soft_clear;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && dev_en_r[SOFT_RESET_BIT] |=> !dev_en_r[SOFT_RESET_BIT] || !clk_en_i;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset stuck");

  property p_standby;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && !pos_on && !neg_on |=> !boost_en_o;
  endproperty
  a_standby: assert property (p_standby) else $error("boost on in standby");

  property p_direct_pin;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && mode == MODE_DIRECT && bias_ctl_r[PIN_SEL_BIT] && !hold_rst && !latch_r
    |=> pos_en_o == $past(pos_pin_s) && neg_en_o == $past(neg_pin_s);
  endproperty
  a_direct_pin: assert property (p_direct_pin) else $error("pin enable mismatch");

  property p_direct_bit;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && mode == MODE_DIRECT && !bias_ctl_r[PIN_SEL_BIT] && !hold_rst && !latch_r
    |=> pos_en_o == $past(bias_ctl_r[POS_EN_BIT]);
  endproperty
  a_direct_bit: assert property (p_direct_bit) else $error("bit enable mismatch");

  property p_seq_order;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(neg_en_o) |-> pos_en_o || !is_auto;
  endproperty
  a_seq_order: assert property (p_seq_order) else $error("negative before positive");

  property p_wake;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && (mode == MODE_WAKE_PASS || mode == MODE_WAKE_REG) && !neg_pin_s
    |=> !pos_en_o && !neg_en_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake rail on with pin low");

  property p_flag_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && pos_hit && !hold_rst |=> flags_r[POS_SHORT_BIT];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("short flag lost");

  property p_disch;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pos_disch_o |-> !pos_en_o;
  endproperty
  a_disch: assert property (p_disch) else $error("discharge on live rail");

endmodule : display_bias_enable_control

// file: src/bias_ctrl_pkg.sv
/*
  shared constants for the display bias enable control block: register
  offsets, field positions, reset values, mode codes and filter times.
  assumes a 50 mhz reference clock and an 8-bit register port.
*/
package bias_ctrl_pkg;

  // register offsets on the 8-bit register port
  localparam logic [7:0] ADDR_DEVICE_ENABLE  = 8'h08;
  localparam logic [7:0] ADDR_BIAS_CONTROL   = 8'h09;
  localparam logic [7:0] ADDR_SHORT_RESPONSE = 8'h0a;
  localparam logic [7:0] ADDR_SHORT_FILTER   = 8'h0b;
  localparam logic [7:0] ADDR_FAULT_FLAGS    = 8'h0f;

  // reset values
  localparam logic [7:0] RST_DEVICE_ENABLE  = 8'h00;
  localparam logic [7:0] RST_BIAS_CONTROL   = 8'h00;
  localparam logic [7:0] RST_SHORT_RESPONSE = 8'h00;
  localparam logic [7:0] RST_SHORT_FILTER   = 8'h00;

  // field positions
  localparam int SOFT_RESET_BIT  = 7;
  localparam int MODE_MSB        = 7;
  localparam int MODE_LSB        = 5;
  localparam int POS_DISCH_BIT   = 4;
  localparam int NEG_DISCH_BIT   = 3;
  localparam int POS_EN_BIT      = 2;
  localparam int NEG_EN_BIT      = 1;
  localparam int PIN_SEL_BIT     = 0;
  localparam int RESP_MSB        = 7;
  localparam int RESP_LSB        = 6;
  localparam int POS_FILT_MSB    = 3;
  localparam int POS_FILT_LSB    = 2;
  localparam int NEG_FILT_MSB    = 1;
  localparam int NEG_FILT_LSB    = 0;
  localparam int OVP_FLAG_BIT    = 5;
  localparam int POS_SHORT_BIT   = 3;
  localparam int NEG_SHORT_BIT   = 2;

  // mode codes
  typedef enum logic [2:0] {
    MODE_PIN_ONLY  = 3'h0,
    MODE_DIRECT    = 3'h4,
    MODE_AUTO_SEQ  = 3'h5,
    MODE_WAKE_PASS = 3'h6,
    MODE_WAKE_REG  = 3'h7
  } bias_mode_t;

  // short response codes
  localparam logic [1:0] RESP_REPORT   = 2'h0;
  localparam logic [1:0] RESP_OFF_BIAS = 2'h1;
  localparam logic [1:0] RESP_OFF_ALL  = 2'h2;

  // clock and filter times
  localparam int CLK_HZ       = 50_000_000;
  localparam int FILT_100_US  = 100;
  localparam int FILT_500_US  = 500;
  localparam int FILT_1_MS    = 1;
  localparam int FILT_2_MS    = 2;
  localparam int CYC_100_US   = (CLK_HZ / 1_000_000) * FILT_100_US;
  localparam int CYC_500_US   = (CLK_HZ / 1_000_000) * FILT_500_US;
  localparam int CYC_1_MS     = (CLK_HZ / 1_000) * FILT_1_MS;
  localparam int CYC_2_MS     = (CLK_HZ / 1_000) * FILT_2_MS;
  localparam int SEQ_DELAY_US = 1000;
  localparam int CYC_SEQ      = (CLK_HZ / 1_000_000) * SEQ_DELAY_US;
  localparam int CNT_W        = 17;

endpackage : bias_ctrl_pkg

// file: src/short_filter.sv
/*
  persistence filter for one short-circuit detector: the condition must
  hold for the selected count before the output pulses once.
  assumes the detector input is already synchronised to the clock.
*/
module short_filter
  import bias_ctrl_pkg::*;
#(
  parameter int T_100 = CYC_100_US,
  parameter int T_500 = CYC_500_US,
  parameter int T_1M  = CYC_1_MS,
  parameter int T_2M  = CYC_2_MS
) (
  input  wire logic       ref_clk_i,  // reference clock
  input  wire logic       sys_rst_i,  // async reset, active high
  input  wire logic       clk_en_i,   // freezes state when low
  input  wire logic       clear_i,    // restart filter
  input  wire logic       cond_i,     // raw short condition
  input  wire logic [1:0] sel_i,      // filter time select
  output logic            hit_o       // one-cycle detection pulse
);

  logic [CNT_W-1:0] cnt_r;   // persistence counter
  logic             done_r;  // already reported this episode

  // threshold per select code
  function automatic logic [CNT_W-1:0] limit_f(input logic [1:0] s);
    case (s)
      2'h0:    limit_f = CNT_W'(T_100);
      2'h1:    limit_f = CNT_W'(T_500);
      2'h2:    limit_f = CNT_W'(T_1M);
      default: limit_f = CNT_W'(T_2M);
    endcase
  endfunction : limit_f

  // counter runs only while the condition persists; a gap restarts it
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
      hit_o  <= 1'b0;
    end else if (clk_en_i) begin
      hit_o <= 1'b0;
      if (clear_i || !cond_i) begin
        cnt_r  <= '0;
        done_r <= 1'b0;
      end else if (!done_r) begin
        if (cnt_r + CNT_W'(1) >= limit_f(sel_i)) begin
          hit_o  <= 1'b1;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + CNT_W'(1);
        end
      end
    end
  end

endmodule : short_filter

// file: src/sync2.sv
/*
  two-flop synchroniser for a bundle of asynchronous pin levels.
  assumes each bit is an independent slow level.
*/
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,  // reference clock
  input  wire logic         sys_rst_i,  // async reset, active high
  input  wire logic         clk_en_i,   // freezes state when low
  input  wire logic [W-1:0] d_i,        // asynchronous levels
  output logic      [W-1:0] q_o         // synchronised levels
);

  logic [W-1:0] meta_r;  // first stage, read only by second stage

  // plain two-stage chain
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else if (clk_en_i) begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule : sync2

// file: tb/host_model.sv
/*
  host side of the register port: one-cycle write and read strobes.
  assumes the bench calls its tasks and feeds back the read data.
*/
module host_model (
  input  wire logic       ref_clk_i,    // reference clock
  output logic            reg_wr_o,     // write strobe
  output logic            reg_rd_o,     // read strobe
  output logic [7:0]      reg_addr_o,   // offset
  output logic [7:0]      reg_wdata_o,  // write data
  input  wire logic [7:0] reg_rdata_i   // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
  end
  // released data is inverted so a stale value cannot pass for live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) #1;
    {reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b1, a, d};
    @(posedge ref_clk_i) #1;
    {reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b0, ~a, ~d};
  endtask : wr
  // data is registered on the edge that samples the strobe and is read one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i) #1;
    {reg_rd_o, reg_addr_o} = {1'b1, a};
    @(posedge ref_clk_i) #1;
    {reg_rd_o, reg_addr_o} = {1'b0, ~a};
    @(posedge ref_clk_i) #1;
    d = reg_rdata_i;
  endtask : rd
endmodule : host_model

// file: tb/display_bias_enable_control_tb.sv
/*
  self-checking bench for the bias enable control block.
  assumes shortened filter counts of 10 cycles and a 50 mhz clock.
*/
module display_bias_enable_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, gen = 0, ppin = 0, npin = 0, ovp = 0, ocp = 0, nsh = 0;
  logic wr, rd, be, pe, ne, pt, pd, nd, bl;
  logic [7:0] ad, wd, rdat, r, pto, nto, bto;
  logic [7:0] tpos = 8'h11, tneg = 8'h22, tbst = 8'h33;
  int num_errors = 0, n_tests = 0;
  initial forever #10 clk = ~clk;
  host_model u_host_model (.ref_clk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(ad),
    .reg_wdata_o(wd), .reg_rdata_i(rdat));
  display_bias_enable_control #(.SEQ_CYC(20), .F100_CYC(10), .F500_CYC(10), .F1M_CYC(10),
    .F2M_CYC(10)) u_display_bias_enable_control (.ref_clk_i(clk), .sys_rst_i(rst),
    .clk_en_i(1'b1), .global_enable_pin_i(gen), .pos_rail_enable_pin_i(ppin),
    .neg_rail_enable_pin_i(npin), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(ad),
    .reg_wdata_i(wd), .pos_target_i(tpos), .neg_target_i(tneg), .boost_target_i(tbst),
    .boost_ovp_i(ovp), .pos_ocp_i(ocp), .neg_short_i(nsh), .reg_rdata_o(rdat),
    .boost_en_o(be), .pos_en_o(pe), .neg_en_o(ne), .passthrough_o(pt), .pos_disch_o(pd),
    .neg_disch_o(nd), .pos_target_o(pto), .neg_target_o(nto), .boost_target_o(bto),
    .backlight_off_o(bl));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wrap_up;
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // bits drive rails, then both enable bits clear with discharge
  task automatic t_bits;
    u_host_model.wr(8'h09, 8'h94);
    tick(5);
    chk({be, pe, ne, nd}, 8'h0c);
    u_host_model.wr(8'h09, 8'h90);
    tick(5);
    chk({be, pe, pd}, 8'h01);
  endtask : t_bits
  // pins drive rails, bits ignored
  task automatic t_pins;
    npin = 1;
    u_host_model.wr(8'h09, 8'h85);
    tick(5);
    chk({pe, ne}, 8'h01);
    tpos = 8'h5a;
    ppin = 1;
    tick(5);
    chk({pe, ne}, 8'h03);
    chk(pto, 8'h5a);
    tpos = 8'h66;
    tbst = 8'h3c;
    tick(2);
    chk(pto, 8'h5a);
    chk(bto, 8'h3c);
    {ppin, npin} = 2'b00;
  endtask : t_pins
  // auto sequence: positive first, delayed negative, reverse off
  task automatic t_auto;
    u_host_model.wr(8'h09, 8'ha6);
    tick(5);
    chk({pe, ne}, 8'h02);
    tick(25);
    chk({pe, ne}, 8'h03);
    u_host_model.wr(8'h09, 8'ha0);
    tick(5);
    chk({pe, ne}, 8'h02);
    tick(25);
    chk({pe, ne, be}, 8'h00);
  endtask : t_auto
  // wake modes gated by the negative rail pin
  task automatic t_wake;
    npin = 1;
    u_host_model.wr(8'h09, 8'hc4);
    tick(5);
    chk({pe, ne, pt, nd}, 8'h0b);
    npin = 0;
    tick(5);
    chk({pe, pt}, 8'h00);
    npin = 1;
    u_host_model.wr(8'h09, 8'he6);
    tick(5);
    chk({pe, ne, pt}, 8'h06);
    npin = 0;
    tick(5);
    chk({pe, ne}, 8'h00);
  endtask : t_wake
  // filtered short and overvoltage flags, clear on read
  task automatic t_short;
    u_host_model.wr(8'h0b, 8'h00);
    u_host_model.wr(8'h0a, 8'h40);
    u_host_model.wr(8'h09, 8'h84);
    ocp = 1;
    nsh = 1;
    ovp = 1;
    u_host_model.rd(8'h0f, r);
    chk(r & 8'h08, 8'h00);
    tick(30);
    {ocp, ovp, nsh} = 3'b000;
    tick(5);
    chk({pe, bl}, 8'h00);
    u_host_model.rd(8'h0f, r);
    chk(r, 8'h2c);
    u_host_model.rd(8'h0f, r);
    chk(r, 8'h00);
  endtask : t_short
  // soft reset restores defaults and self clears
  task automatic t_soft;
    u_host_model.wr(8'h08, 8'h80);
    tick(3);
    u_host_model.rd(8'h09, r);
    chk(r, 8'h00);
    u_host_model.rd(8'h08, r);
    chk(r, 8'h00);
  endtask : t_soft
  // enable pin low shuts everything down
  task automatic t_off;
    u_host_model.wr(8'h09, 8'h94);
    tick(5);
    gen = 0;
    tick(5);
    chk({be, pe}, 8'h00);
    gen = 1;
    tick(5);
    u_host_model.rd(8'h09, r);
    chk(r, 8'h00);
  endtask : t_off
  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end
  initial begin
    tick(6);
    rst = 0;
    gen = 1;
    tick(5);
    t_bits();
    t_pins();
    t_short();
    t_auto();
    t_wake();
    t_soft();
    t_off();
    wrap_up();
  end
endmodule : display_bias_enable_control_tb
